// File: inc/ddr3_init_cfg_pkg.sv
// holds the constants and types shared by the mode value and rank config block
// assumes dword configuration accesses and a training engine on the same clock
// Contract
// - mode register one value sits in bits 31:16
// - mode register zero value sits in bits 15:0
// - stored values feed automated mode register writes
// - mode register two value at 74h bits 15:0
// - training uses stored mode two and control words
// - control word two written on command timing change
// - hardware drives bit 21; others pass unchanged
// - control word zero written on inversion change
// - hardware drives bit 16; bits 19:17 unchanged
// - eight bit rank vector, resets to zero
// - two dimms: four ranks per dimm
// - three dimms: two ranks per slot
`default_nettype none
package ddr3_init_cfg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets and reset values
   localparam logic [7:0]  MODE01_OFS     = 8'h70;
   localparam logic [7:0]  MODE2_OFS      = 8'h74;
   localparam logic [7:0]  RANK_OFS       = 8'h7C;
   localparam logic [31:0] MODE01_RST     = 32'h0000_0000;
   localparam logic [23:0] MODE2_RST      = 24'h00_0000;
   localparam logic [7:0]  RANK_RST       = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int MR1_MSB     = 31;
   localparam int MR1_LSB     = 16;
   localparam int MR0_MSB     = 15;
   localparam int MR0_LSB     = 0;
   localparam int MR2_MSB     = 15;
   localparam int MR2_LSB     = 0;
   localparam int RC2_MSB     = 23;
   localparam int RC2_LSB     = 20;
   localparam int RC2_HW_BIT  = 21;
   localparam int RC0_MSB     = 19;
   localparam int RC0_LSB     = 16;
   localparam int RC0_HW_BIT  = 16;
   localparam int MODE2_W     = 24;
   localparam int RANK_W      = 8;

   ////////////////////////////////////////////////////////////////////////////
   // command encodings
   localparam logic [2:0] MR0_SEL   = 3'h0;
   localparam logic [2:0] MR1_SEL   = 3'h1;
   localparam logic [2:0] MR2_SEL   = 3'h2;
   localparam logic [2:0] RC0_NUM   = 3'h0;
   localparam logic [2:0] RC2_NUM   = 3'h2;

   typedef enum logic [0:0] {
      CMD_MRS = 1'b0,
      CMD_RCW = 1'b1
   } cmd_kind_e;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } seq_state_e;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } cfg_req_s;

   typedef struct packed {
      cmd_kind_e   kind;
      logic [2:0]  rank;
      logic [2:0]  ba;
      logic [15:0] addr;
   } cmd_s;

endpackage
`default_nettype wire

// File: src/rank_locate.sv
// maps a slot and rank within the slot onto the rank-present vector
// assumes the population mode input is steady while a command is prepared
`timescale 1ns/1ps
`default_nettype none
module rank_locate (
   input  wire logic       i_three_dimm,
   input  wire logic [1:0] i_slot,
   input  wire logic [1:0] i_rank,
   input  wire logic [7:0] i_present,
   output logic      [2:0] o_bit,
   output logic            o_rank_ok,
   output logic            o_slot_ok
);
   logic [3:0] slot_bits;

   always_comb begin
      slot_bits = 4'h0;
      if (i_three_dimm) begin
         // pairs: slot 0 -> 1:0, slot 1 -> 3:2, slot 2 -> 5:4
         o_bit = {i_slot, i_rank[0]};
         if (i_slot != 2'h3) begin
            slot_bits = {2'h0, i_present[{i_slot, 1'b0} +: 2]};
         end
         o_rank_ok = (i_slot != 2'h3) && !i_rank[1] && i_present[o_bit];
      end else begin
         // nibbles: first dimm 3:0, second dimm 7:4
         o_bit = {i_slot[0], i_rank};
         if (!i_slot[1]) begin
            slot_bits = i_present[{i_slot[0], 2'h0} +: 4];
         end
         o_rank_ok = !i_slot[1] && i_present[o_bit];
      end
      o_slot_ok = |slot_bits;
   end
endmodule
`default_nettype wire

// File: src/ddr3_init_cfg.sv
// mode register init values, registered-dimm control words and rank vector,
// plus the issue path that turns training requests into dram commands
// assumes training requests come from logic on i_clk; command sink on i_clk
`timescale 1ns/1ps
`default_nettype none
module ddr3_init_cfg (
   input  wire logic                         i_clk,
   input  wire logic                         i_nrst,
   input  wire ddr3_init_cfg_pkg::cfg_req_s  i_cfg,
   output logic                       [31:0] o_cfg_rdata,
   output logic                              o_cfg_ack,
   input  wire logic                         i_three_dimm,
   input  wire logic                         i_mrs_req,
   input  wire logic                   [2:0] i_mrs_sel,
   input  wire logic                   [1:0] i_mrs_slot,
   input  wire logic                   [1:0] i_mrs_rank,
   output logic                              o_mrs_busy,
   input  wire logic                         i_inv_change,
   input  wire logic                         i_inv_enable,
   input  wire logic                   [1:0] i_inv_slot,
   input  wire logic                         i_timing_change,
   input  wire logic                         i_timing_3t,
   input  wire logic                   [1:0] i_timing_slot,
   output ddr3_init_cfg_pkg::cmd_s           o_cmd,
   output logic                              o_cmd_valid,
   input  wire logic                         i_cmd_ready,
   output logic                              o_cmd_skip,
   output logic                        [7:0] o_rank_present
);

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic [31:0] mode01_r, mode01_nxt;
   logic [23:0] mode2_r, mode2_nxt;
   logic [7:0]  rank_r, rank_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        ack_r, ack_nxt;

   function automatic logic [31:0] read_mux(input logic [7:0]  a,
                                            input logic [31:0] m01,
                                            input logic [23:0] m2,
                                            input logic [7:0]  rk);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         ddr3_init_cfg_pkg::MODE01_OFS: v = m01;
         ddr3_init_cfg_pkg::MODE2_OFS:  v = {8'h00, m2};
         ddr3_init_cfg_pkg::RANK_OFS:   v = {24'h00_0000, rk};
         default:                       v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   always_comb begin
      mode01_nxt = mode01_r;
      mode2_nxt  = mode2_r;
      rank_nxt   = rank_r;
      if (i_cfg.wr) begin
         case (i_cfg.addr)
            ddr3_init_cfg_pkg::MODE01_OFS: mode01_nxt = i_cfg.wdata;
            ddr3_init_cfg_pkg::MODE2_OFS:  mode2_nxt  = i_cfg.wdata[23:0];
            ddr3_init_cfg_pkg::RANK_OFS:   rank_nxt   = i_cfg.wdata[7:0];
            default: ;
         endcase
      end
      // unmapped offsets read zero and ignore writes
      rdata_nxt = i_cfg.rd ? read_mux(i_cfg.addr, mode01_r, mode2_r, rank_r) : rdata_r;
      ack_nxt   = i_cfg.rd | i_cfg.wr;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mode01_r <= ddr3_init_cfg_pkg::MODE01_RST;
         mode2_r  <= ddr3_init_cfg_pkg::MODE2_RST;
         rank_r   <= ddr3_init_cfg_pkg::RANK_RST;
         rdata_r  <= 32'h0000_0000;
         ack_r    <= 1'b0;
      end else begin
         mode01_r <= mode01_nxt;
         mode2_r  <= mode2_nxt;
         rank_r   <= rank_nxt;
         rdata_r  <= rdata_nxt;
         ack_r    <= ack_nxt;
      end
   end

   assign o_cfg_rdata    = rdata_r;
   assign o_cfg_ack      = ack_r;
   assign o_rank_present = rank_r;

   ////////////////////////////////////////////////////////////////////////////
   // pending training requests
   logic       rc0_pend_r, rc0_pend_nxt;
   logic       rc2_pend_r, rc2_pend_nxt;
   logic       mrs_pend_r, mrs_pend_nxt;
   logic       inv_en_r, inv_en_nxt;
   logic       t3_r, t3_nxt;
   logic [1:0] rc0_slot_r, rc0_slot_nxt;
   logic [1:0] rc2_slot_r, rc2_slot_nxt;
   logic [2:0] mrs_sel_r, mrs_sel_nxt;
   logic [1:0] mrs_slot_r, mrs_slot_nxt;
   logic [1:0] mrs_rank_r, mrs_rank_nxt;
   logic       rc0_done, rc2_done, mrs_done;

   ////////////////////////////////////////////////////////////////////////////
   // issue sequencer
   ddr3_init_cfg_pkg::seq_state_e state_r, state_nxt;
   ddr3_init_cfg_pkg::cmd_s       cmd_r, cmd_nxt;
   logic                          valid_r, valid_nxt;
   logic                          skip_r, skip_nxt;
   logic [1:0]                    pick_slot;
   logic [1:0]                    pick_rank;
   logic [2:0]                    loc_bit;
   logic                          loc_rank_ok;
   logic                          loc_slot_ok;

   always_comb begin
      // a new inversion or timing event wins over the clear of its own pending flag; a mode request while one is pending is dropped
      rc0_pend_nxt = i_inv_change | (rc0_pend_r & ~rc0_done);
      rc2_pend_nxt = i_timing_change | (rc2_pend_r & ~rc2_done);
      mrs_pend_nxt = (i_mrs_req & ~mrs_pend_r) | (mrs_pend_r & ~mrs_done);
      inv_en_nxt   = i_inv_change ? i_inv_enable : inv_en_r;
      t3_nxt       = i_timing_change ? i_timing_3t : t3_r;
      rc0_slot_nxt = i_inv_change ? i_inv_slot : rc0_slot_r;
      rc2_slot_nxt = i_timing_change ? i_timing_slot : rc2_slot_r;
      mrs_sel_nxt  = (i_mrs_req & ~mrs_pend_r) ? i_mrs_sel : mrs_sel_r;
      mrs_slot_nxt = (i_mrs_req & ~mrs_pend_r) ? i_mrs_slot : mrs_slot_r;
      mrs_rank_nxt = (i_mrs_req & ~mrs_pend_r) ? i_mrs_rank : mrs_rank_r;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rc0_pend_r <= 1'b0;
         rc2_pend_r <= 1'b0;
         mrs_pend_r <= 1'b0;
         inv_en_r   <= 1'b0;
         t3_r       <= 1'b0;
         rc0_slot_r <= 2'h0;
         rc2_slot_r <= 2'h0;
         mrs_sel_r  <= 3'h0;
         mrs_slot_r <= 2'h0;
         mrs_rank_r <= 2'h0;
      end else begin
         rc0_pend_r <= rc0_pend_nxt;
         rc2_pend_r <= rc2_pend_nxt;
         mrs_pend_r <= mrs_pend_nxt;
         inv_en_r   <= inv_en_nxt;
         t3_r       <= t3_nxt;
         rc0_slot_r <= rc0_slot_nxt;
         rc2_slot_r <= rc2_slot_nxt;
         mrs_sel_r  <= mrs_sel_nxt;
         mrs_slot_r <= mrs_slot_nxt;
         mrs_rank_r <= mrs_rank_nxt;
      end
   end

   assign o_mrs_busy = mrs_pend_r;

   // control words outrank mode writes: the dimm buffer must track timing first
   always_comb begin
      if (rc0_pend_r) begin
         pick_slot = rc0_slot_r;
         pick_rank = 2'h0;
      end else if (rc2_pend_r) begin
         pick_slot = rc2_slot_r;
         pick_rank = 2'h0;
      end else begin
         pick_slot = mrs_slot_r;
         pick_rank = mrs_rank_r;
      end
   end

   rank_locate u_locate (
      .i_three_dimm (i_three_dimm),
      .i_slot       (pick_slot),
      .i_rank       (pick_rank),
      .i_present    (rank_r),
      .o_bit        (loc_bit),
      .o_rank_ok    (loc_rank_ok),
      .o_slot_ok    (loc_slot_ok)
   );

   always_comb begin
      state_nxt = state_r;
      cmd_nxt   = cmd_r;
      valid_nxt = valid_r;
      skip_nxt  = 1'b0;
      rc0_done  = 1'b0;
      rc2_done  = 1'b0;
      mrs_done  = 1'b0;
      case (state_r)
         ddr3_init_cfg_pkg::ST_IDLE: begin
            if (rc0_pend_r) begin
               rc0_done = ~loc_slot_ok;
               skip_nxt = ~loc_slot_ok;
               cmd_nxt.kind = ddr3_init_cfg_pkg::CMD_RCW;
               cmd_nxt.ba   = ddr3_init_cfg_pkg::RC0_NUM;
               cmd_nxt.rank = loc_bit;
               // stored 19:17 pass through, bit 16 follows inversion state
               cmd_nxt.addr = {12'h000,
                               mode2_r[ddr3_init_cfg_pkg::RC0_MSB:ddr3_init_cfg_pkg::RC0_HW_BIT+1],
                               inv_en_r};
            end else if (rc2_pend_r) begin
               rc2_done = ~loc_slot_ok;
               skip_nxt = ~loc_slot_ok;
               cmd_nxt.kind = ddr3_init_cfg_pkg::CMD_RCW;
               cmd_nxt.ba   = ddr3_init_cfg_pkg::RC2_NUM;
               cmd_nxt.rank = loc_bit;
               cmd_nxt.addr = {12'h000,
                               mode2_r[ddr3_init_cfg_pkg::RC2_MSB:ddr3_init_cfg_pkg::RC2_HW_BIT+1],
                               t3_r,
                               mode2_r[ddr3_init_cfg_pkg::RC2_LSB]};
            end else if (mrs_pend_r) begin
               mrs_done = ~loc_rank_ok;
               skip_nxt = ~loc_rank_ok;
               cmd_nxt.kind = ddr3_init_cfg_pkg::CMD_MRS;
               cmd_nxt.ba   = mrs_sel_r;
               cmd_nxt.rank = loc_bit;
               case (mrs_sel_r)
                  ddr3_init_cfg_pkg::MR0_SEL:
                     cmd_nxt.addr = mode01_r[ddr3_init_cfg_pkg::MR0_MSB:ddr3_init_cfg_pkg::MR0_LSB];
                  ddr3_init_cfg_pkg::MR1_SEL:
                     cmd_nxt.addr = mode01_r[ddr3_init_cfg_pkg::MR1_MSB:ddr3_init_cfg_pkg::MR1_LSB];
                  ddr3_init_cfg_pkg::MR2_SEL:
                     cmd_nxt.addr = mode2_r[ddr3_init_cfg_pkg::MR2_MSB:ddr3_init_cfg_pkg::MR2_LSB];
                  default:
                     cmd_nxt.addr = 16'h0000;
               endcase
            end
            if ((rc0_pend_r | rc2_pend_r) ? loc_slot_ok : (mrs_pend_r & loc_rank_ok)) begin
               valid_nxt = 1'b1;
               state_nxt = ddr3_init_cfg_pkg::ST_SEND;
            end
         end
         ddr3_init_cfg_pkg::ST_SEND: begin
            if (i_cmd_ready) begin
               valid_nxt = 1'b0;
               state_nxt = ddr3_init_cfg_pkg::ST_IDLE;
               if (cmd_r.kind == ddr3_init_cfg_pkg::CMD_MRS) begin
                  mrs_done = 1'b1;
               end else if (cmd_r.ba == ddr3_init_cfg_pkg::RC0_NUM) begin
                  rc0_done = 1'b1;
               end else begin
                  rc2_done = 1'b1;
               end
            end
         end
         default: begin
            state_nxt = ddr3_init_cfg_pkg::ST_IDLE;
            valid_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= ddr3_init_cfg_pkg::ST_IDLE;
         cmd_r   <= '0;
         valid_r <= 1'b0;
         skip_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cmd_r   <= cmd_nxt;
         valid_r <= valid_nxt;
         skip_r  <= skip_nxt;
      end
   end

   assign o_cmd       = cmd_r;
   assign o_cmd_valid = valid_r;
   assign o_cmd_skip  = skip_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence inv_event_s;
      i_inv_change && state_r == ddr3_init_cfg_pkg::ST_IDLE && !rc0_pend_r && !rc2_pend_r;
   endsequence

   sequence rc0_out_s;
      (o_cmd_valid && o_cmd.kind == ddr3_init_cfg_pkg::CMD_RCW
       && o_cmd.ba == ddr3_init_cfg_pkg::RC0_NUM) || o_cmd_skip;
   endsequence

   mode01_write_a: assert property (i_cfg.wr && i_cfg.addr == ddr3_init_cfg_pkg::MODE01_OFS
      |=> mode01_r == $past(i_cfg.wdata)) else $error("mode 0/1 write lost");
   mr1_value_a: assert property ($rose(o_cmd_valid) && o_cmd.kind == ddr3_init_cfg_pkg::CMD_MRS
      && o_cmd.ba == ddr3_init_cfg_pkg::MR1_SEL |-> o_cmd.addr == mode01_r[31:16])
      else $error("mr1 value wrong");
   mr0_value_a: assert property ($rose(o_cmd_valid) && o_cmd.kind == ddr3_init_cfg_pkg::CMD_MRS
      && o_cmd.ba == ddr3_init_cfg_pkg::MR0_SEL |-> o_cmd.addr == mode01_r[15:0])
      else $error("mr0 value wrong");
   mr2_value_a: assert property ($rose(o_cmd_valid) && o_cmd.kind == ddr3_init_cfg_pkg::CMD_MRS
      && o_cmd.ba == ddr3_init_cfg_pkg::MR2_SEL |-> o_cmd.addr == mode2_r[15:0])
      else $error("mr2 value wrong");
   rc2_bits_a: assert property ($rose(o_cmd_valid) && o_cmd.kind == ddr3_init_cfg_pkg::CMD_RCW
      && o_cmd.ba == ddr3_init_cfg_pkg::RC2_NUM |-> o_cmd.addr[3:2] == mode2_r[23:22]
      && o_cmd.addr[0] == mode2_r[20] && o_cmd.addr[1] == t3_r)
      else $error("control word two bits wrong");
   rc0_bits_a: assert property ($rose(o_cmd_valid) && o_cmd.kind == ddr3_init_cfg_pkg::CMD_RCW
      && o_cmd.ba == ddr3_init_cfg_pkg::RC0_NUM |-> o_cmd.addr[3:1] == mode2_r[19:17]
      && o_cmd.addr[0] == inv_en_r)
      else $error("control word zero bits wrong");
   rc0_issue_a: assert property (inv_event_s |-> ##[1:3] rc0_out_s)
      else $error("inversion change not followed by control word zero");
   absent_rank_a: assert property ($rose(o_cmd_valid) && o_cmd.kind == ddr3_init_cfg_pkg::CMD_MRS
      |-> rank_r[o_cmd.rank]) else $error("command to absent rank");
   rank_read_a: assert property (i_cfg.rd && i_cfg.addr == ddr3_init_cfg_pkg::RANK_OFS
      |=> o_cfg_ack && o_cfg_rdata == {24'h00_0000, $past(rank_r)})
      else $error("rank vector read wrong");
   cmd_hold_a: assert property (o_cmd_valid && !i_cmd_ready |=> o_cmd_valid && $stable(o_cmd))
      else $error("command dropped before ready");

endmodule
`default_nettype wire

// File: sim/cmd_sink.sv
// command sink standing in for the dram devices and the register buffer
// assumes valid and command are launched from registers on i_clk
`timescale 1ns/1ps
`default_nettype none
module cmd_sink (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_valid,
   input  wire logic i_slow,
   output logic      o_ready
);
   logic [1:0] wait_r;
   logic [1:0] wait_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // slow mode makes the controller hold each command for four cycles
   always_comb begin
      wait_nxt = wait_r + 2'h1;
      if (!i_valid || o_ready) begin
         wait_nxt = 2'h0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wait_r <= 2'h0;
      end else begin
         wait_r <= wait_nxt;
      end
   end

   // ready only while a command stands, never ahead of it
   assign o_ready = i_valid && (!i_slow || wait_r == 2'h3);
endmodule
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the mode value, control word and rank vector block
// assumes cmd_sink as the far side and a 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                        clk = 1'b0;
   logic                        nrst = 1'b0;
   ddr3_init_cfg_pkg::cfg_req_s cfg = '0;
   logic [31:0]                 rdata;
   logic                        ack, busy, valid, ready, skip, slow = 1'b0;
   logic                        three = 1'b0, mrs_req = 1'b0, inv_chg = 1'b0;
   logic                        inv_en = 1'b0, tim_chg = 1'b0, tim_3t = 1'b0;
   logic [2:0]                  mrs_sel = 3'h0;
   logic [1:0]                  mrs_slot = 2'h0, mrs_rank = 2'h0;
   logic [1:0]                  inv_slot = 2'h0, tim_slot = 2'h0;
   logic [7:0]                  present;
   ddr3_init_cfg_pkg::cmd_s     cmd;
   int                          fail_count = 0, checks_done = 0, cycles = 0;

   always #12.5 clk = ~clk;

   ddr3_init_cfg dut (.i_clk(clk), .i_nrst(nrst), .i_cfg(cfg), .o_cfg_rdata(rdata),
      .o_cfg_ack(ack), .i_three_dimm(three), .i_mrs_req(mrs_req), .i_mrs_sel(mrs_sel),
      .i_mrs_slot(mrs_slot), .i_mrs_rank(mrs_rank), .o_mrs_busy(busy),
      .i_inv_change(inv_chg), .i_inv_enable(inv_en), .i_inv_slot(inv_slot),
      .i_timing_change(tim_chg), .i_timing_3t(tim_3t), .i_timing_slot(tim_slot),
      .o_cmd(cmd), .o_cmd_valid(valid), .i_cmd_ready(ready), .o_cmd_skip(skip),
      .o_rank_present(present));

   cmd_sink sink (.i_clk(clk), .i_nrst(nrst), .i_valid(valid), .i_slow(slow),
      .o_ready(ready));

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // generous ceiling; the whole sequence needs under a hundred cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         test_done;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk);
      cfg <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      cfg <= '0;
      #1;
      chk({31'h0, ack}, 32'h1);
      r = rdata;
   endtask

   task automatic reg_rw(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      logic [31:0] r;
      acc(1'b1, a, d, r);
      acc(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask

   // waits for a command or a skip, then times how long the command stands
   task automatic wait_cmd(input logic sk, input logic [22:0] exp);
      int n;
      n = 1;
      repeat (10) begin
         @(posedge clk);
         #1;
         if (valid === 1'b1 || skip === 1'b1) break;
      end
      chk({31'h0, skip}, {31'h0, sk});
      if (!sk) begin
         chk({9'h0, cmd}, {9'h0, exp});
         while (n < 9) begin
            @(posedge clk);
            #1;
            if (valid !== 1'b1) break;
            n++;
         end
         chk(n, slow ? 32'h4 : 32'h1);
      end
   endtask

   task automatic mrs(input logic [2:0] s, input logic [1:0] sl, input logic [1:0] rk);
      @(posedge clk);
      mrs_req <= 1'b1;
      mrs_sel <= s;
      mrs_slot <= sl;
      mrs_rank <= rk;
      @(posedge clk);
      mrs_req <= 1'b0;
      #1;
      chk({31'h0, busy}, 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] r;
      acc(1'b0, 8'h70, 32'h0, r);
      chk(r, 32'h0);
      acc(1'b0, 8'h74, 32'h0, r);
      chk(r, 32'h0);
      acc(1'b0, 8'h7C, 32'h0, r);
      chk(r, 32'h0);
   endtask

   task automatic t_regs;
      reg_rw(8'h70, 32'hA5A5_3C3C, 32'hA5A5_3C3C);
      reg_rw(8'h74, 32'hFFE5_1234, 32'h00E5_1234);
      reg_rw(8'h7C, 32'hFFFF_FF50, 32'h0000_0050);
      reg_rw(8'h78, 32'hFFFF_FFFF, 32'h0000_0000);
      chk({24'h0, present}, 32'h0000_0050);
   endtask

   task automatic t_mrs;
      logic [15:0] v[3];
      v = '{16'h3C3C, 16'hA5A5, 16'h1234};
      three <= 1'b0;
      for (int s = 0; s < 3; s++) begin
         mrs(s[2:0], 2'h1, 2'h2);
         wait_cmd(1'b0, {1'b0, 3'h6, s[2:0], v[s]});
      end
      mrs(3'h0, 2'h0, 2'h0);
      wait_cmd(1'b1, 23'h0);
      three <= 1'b1;
      mrs(3'h2, 2'h2, 2'h0);
      wait_cmd(1'b0, {1'b0, 3'h4, 3'h2, 16'h1234});
      mrs(3'h1, 2'h2, 2'h1);
      wait_cmd(1'b1, 23'h0);
      three <= 1'b0;
   endtask

   // both changes at once: the inversion word goes first, stored bit 21 overridden
   task automatic t_rc;
      slow <= 1'b1;
      @(posedge clk);
      {inv_chg, inv_en, inv_slot} <= {1'b1, 1'b0, 2'h1};
      {tim_chg, tim_3t, tim_slot} <= {1'b1, 1'b0, 2'h1};
      @(posedge clk);
      {inv_chg, tim_chg} <= 2'b00;
      wait_cmd(1'b0, {1'b1, 3'h4, 3'h0, 16'h0004});
      wait_cmd(1'b0, {1'b1, 3'h4, 3'h2, 16'h000C});
      slow <= 1'b0;
      @(posedge clk);
      {tim_chg, tim_3t} <= 2'b11;
      @(posedge clk);
      tim_chg <= 1'b0;
      wait_cmd(1'b0, {1'b1, 3'h4, 3'h2, 16'h000E});
      @(posedge clk);
      {inv_chg, inv_en, inv_slot} <= {1'b1, 1'b1, 2'h0};
      @(posedge clk);
      inv_chg <= 1'b0;
      wait_cmd(1'b1, 23'h0);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_regs;
      t_mrs;
      t_rc;
      test_done;
   end
endmodule
`default_nettype wire
